// ===== hw/ddc_defines.svh
// Register offsets, field positions and reset values of the display data channel controller
`ifndef DDC_DEFINES_SVH
`define DDC_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets on the plain register port
// ----------------------------------------------------------------
`define DDC_OFS_WINDOW    8'hD4
`define DDC_OFS_LDATA     8'hD5
`define DDC_OFS_POINTER   8'hD6
`define DDC_OFS_CONTROL   8'hD7
`define DDC_OFS_IRQ_STAT  8'hD8
`define DDC_OFS_IRQ_MASK  8'hD9
`define DDC_OFS_SHIFT     8'hDA

// ----------------------------------------------------------------
// Control register fields and reset
// ----------------------------------------------------------------
`define DDC_CTL_SIZE      6
`define DDC_CTL_SWACC     5
`define DDC_CTL_WILD      4
`define DDC_CTL_LFLAG     3
`define DDC_CTL_LEN       2
`define DDC_CTL_SFLAG     1
`define DDC_CTL_MODE      0
`define DDC_CTL_RESET     8'h00

// ----------------------------------------------------------------
// Interrupt status and mask bits
// ----------------------------------------------------------------
`define DDC_IRQ_SWITCH    0
`define DDC_IRQ_LBYTE     1
`define DDC_IRQ_IBYTE     2
`define DDC_IRQ_W         3

// ----------------------------------------------------------------
// Buffer, link and address constants
// ----------------------------------------------------------------
`define DDC_BUF_DEPTH     256
`define DDC_AW            8
`define DDC_DW            8
`define DDC_XWIN_HI       8'hFF
`define DDC_SLAVE_ADDR    7'h50
`define DDC_WILD_MASK     7'h78
`define DDC_BITS_BYTE     4'h8
`define DDC_LAST_BIT      4'h7

`endif

// ===== hw/ddc_pkg.sv
// Types of the display data channel controller
package ddc_pkg;
	`include "ddc_defines.svh"

	// ----------------------------------------------------------------
	// Serial slave states
	// ----------------------------------------------------------------
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,   // Waiting for a start
		ST_ADDR = 7'h02,   // Shifting in the address byte
		ST_AACK = 7'h04,   // Acknowledging the address
		ST_RX   = 7'h08,   // Receiving a data byte
		ST_RACK = 7'h10,   // Acknowledging a received byte
		ST_TX   = 7'h20,   // Sending a data byte
		ST_TACK = 7'h40    // Sampling the master's acknowledge
	} ddc_st_t;

	// ----------------------------------------------------------------
	// State of the controller, all but xrd_reg and the buffer contents
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                  size_sel;   // Buffer size select
		logic                  sw_acc;     // Software access enable
		logic                  wild;       // Wildcard address enable
		logic                  legacy_en;  // Legacy mode enable
		logic                  mode;       // 0 legacy, 1 serial bus
		logic [`DDC_IRQ_W-1:0] irq_stat;   // Sticky event flags
		logic [`DDC_IRQ_W-1:0] irq_mask;   // Interrupt mask
		logic [`DDC_AW-1:0]    ptr;        // Buffer pointer
		logic [`DDC_DW-1:0]    ldata;      // Legacy transmit data
		logic [`DDC_DW-1:0]    shdat;      // Serial shift data
		logic [2:0]            vs_s;       // Vsync sync chain
		logic [2:0]            scl_s;      // Clock line sync chain
		logic [2:0]            sda_s;      // Data line sync chain
		logic [`DDC_DW-1:0]    l_sh;       // Legacy shifter
		logic [3:0]            l_cnt;      // Legacy bit count
		ddc_st_t               st;         // Serial state
		logic [`DDC_DW-1:0]    i_sh;       // Serial shifter
		logic [3:0]            i_cnt;      // Serial bit count
		logic                  i_rw;       // Read transfer
		logic                  i_first;    // Next byte is the offset
		logic                  i_nak;      // Master refused a byte
		logic                  i_drive;    // Pull data line low
		logic                  stretch;    // Hold clock line low
		logic [`DDC_DW-1:0]    rdata;      // Register read data
		logic                  rd_buf;     // Read data comes from buffer
	} ddc_state_t;

	localparam ddc_state_t DDC_STATE_RST = '{
		st:      ST_IDLE,
		vs_s:    3'h0,
		scl_s:   3'h7,
		sda_s:   3'h7,
		l_cnt:   `DDC_BITS_BYTE,
		default: '0
	};
endpackage : ddc_pkg

// ===== hw/ddc_buf_if.sv
// Port between the controller and its byte buffer
`timescale 1ns/10ps
`default_nettype none
interface ddc_buf_if;
	logic [7:0] addr;   // Entry index
	logic [7:0] wdata;  // Write data
	logic       we;     // Write strobe
	logic [7:0] rdata;  // Entry read one cycle after addr

	modport ctrl (output addr, output wdata, output we, input rdata);
	modport mem  (input addr, input wdata, input we, output rdata);
endinterface : ddc_buf_if
`default_nettype wire

// ===== hw/ddc_buffer.sv
// Byte buffer of the display data channel controller
`timescale 1ns/10ps
`default_nettype none
`include "ddc_defines.svh"
module ddc_buffer (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	ddc_buf_if.mem    bus
);
	import ddc_pkg::*;

	logic [`DDC_DW-1:0] mem_q [`DDC_BUF_DEPTH]; // Contents undefined at power up
	logic [`DDC_DW-1:0] rdata_reg;              // Registered read port

	// ----------------------------------------------------------------
	// Storage, one flip-flop row per entry
	// ----------------------------------------------------------------
	for (genvar i = 0; i < `DDC_BUF_DEPTH; i++) begin : g_entry
		always_ff @(posedge clk_in) begin
			if (bus.we && bus.addr == 8'(i)) begin
				mem_q[i] <= bus.wdata;
			end
		end
	end

	// Read port; registered so the data stands one cycle behind the index
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= mem_q[bus.addr];
		end
	end

	assign bus.rdata = rdata_reg;
endmodule : ddc_buffer
`default_nettype wire

// ===== hw/ddc_ctrl.sv
// Display data channel controller: legacy vsync transmitter, serial bus slave and buffer control
`timescale 1ns/10ps
`default_nettype none
`include "ddc_defines.svh"
module ddc_ctrl (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [7:0]  reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [7:0]  reg_rdata_out,
	input  wire logic        i2c_enable_in,
	input  wire logic [15:0] xdata_addr_in,
	input  wire logic [7:0]  xdata_wdata_in,
	input  wire logic        xdata_wr_in,
	input  wire logic        xdata_rd_in,
	output logic      [7:0]  xdata_rdata_out,
	output logic             xdata_claim_out,
	input  wire logic        vsync_in,
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe_n_out,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n_out,
	output logic             irq_out
);
	import ddc_pkg::*;

	// ----------------------------------------------------------------
	// State and buffer port
	// ----------------------------------------------------------------
	ddc_state_t s_reg;      // Registered state
	ddc_state_t s_next;     // Next state
	logic       xrd_reg;    // Window read of the buffer pending
	ddc_buf_if  buf_if ();  // Buffer port
	ddc_buffer u_buffer (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.bus      (buf_if.mem)
	);

	// ----------------------------------------------------------------
	// Decode of modes and bus events
	// ----------------------------------------------------------------
	logic enabled;     // Unit active
	logic in_xwin;     // Processor address in the buffer window
	logic win_acc;     // Register window access
	logic x_acc;       // Direct data-space access
	logic vs_rise;     // Vsync rising edge
	logic scl_rise;    // Bus clock rising edge
	logic scl_fall;    // Bus clock falling edge
	logic i_start;     // Start condition
	logic i_stop;      // Stop condition
	logic addr_match;  // Address byte selects us
	logic [7:0] hw_idx; // Buffer index used by the hardware

	assign enabled  = s_reg.legacy_en | i2c_enable_in;
	assign in_xwin  = xdata_addr_in[15:8] == `DDC_XWIN_HI;
	// The processor reaches the buffer only while software access is set
	assign win_acc  = s_reg.sw_acc && (reg_wr_in || reg_rd_in) && reg_addr_in == `DDC_OFS_WINDOW;
	assign x_acc    = s_reg.sw_acc && in_xwin && (xdata_wr_in || xdata_rd_in) && !win_acc;
	// Only the second and third stages are compared; the first stage stays private
	assign vs_rise  = s_reg.vs_s[1] && !s_reg.vs_s[2];
	assign scl_rise = s_reg.scl_s[1] && !s_reg.scl_s[2];
	assign scl_fall = !s_reg.scl_s[1] && s_reg.scl_s[2];
	assign i_start  = s_reg.scl_s[1] && s_reg.scl_s[2] && s_reg.sda_s[2] && !s_reg.sda_s[1];
	assign i_stop   = s_reg.scl_s[1] && s_reg.scl_s[2] && !s_reg.sda_s[2] && s_reg.sda_s[1];
	assign hw_idx   = s_reg.size_sel ? s_reg.ptr : {1'b0, s_reg.ptr[6:0]};
	// Wildcard masks the three low bits of the seven-bit address
	assign addr_match = s_reg.wild ?
		((s_reg.i_sh[7:1] & `DDC_WILD_MASK) == (`DDC_SLAVE_ADDR & `DDC_WILD_MASK)) :
		(s_reg.i_sh[7:1] == `DDC_SLAVE_ADDR);

	// Pointer step; in the small buffer only the low seven bits count and wrap, bit 7 is kept
	function automatic logic [7:0] ptr_step(input logic [7:0] p, input logic big);
		ptr_step = big ? 8'(p + 8'h01) : {p[7], 7'(p[6:0] + 7'h01)};
	endfunction : ptr_step

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic       tx_load;
		logic [7:0] tx_byte;
		tx_load = 1'b0;
		tx_byte = s_reg.shdat;
		s_next  = s_reg;
		s_next.rd_buf = 1'b0;
		// Pin synchronisers
		s_next.vs_s  = {s_reg.vs_s[1:0], vsync_in};
		s_next.scl_s = {s_reg.scl_s[1:0], scl_in};
		s_next.sda_s = {s_reg.sda_s[1:0], sda_in};

		// Register writes; the hardware set further down wins over any clear here
		if (reg_wr_in) begin
			unique case (reg_addr_in)
				`DDC_OFS_LDATA: s_next.ldata = reg_wdata_in;
				`DDC_OFS_POINTER: s_next.ptr = reg_wdata_in;
				`DDC_OFS_CONTROL: begin
					s_next.size_sel  = reg_wdata_in[`DDC_CTL_SIZE];
					s_next.sw_acc    = reg_wdata_in[`DDC_CTL_SWACC];
					s_next.wild      = reg_wdata_in[`DDC_CTL_WILD];
					s_next.legacy_en = reg_wdata_in[`DDC_CTL_LEN];
					// Flags in the control view are cleared by writing zero
					if (!reg_wdata_in[`DDC_CTL_LFLAG]) begin
						s_next.irq_stat[`DDC_IRQ_LBYTE] = 1'b0;
					end
					if (!reg_wdata_in[`DDC_CTL_SFLAG]) begin
						s_next.irq_stat[`DDC_IRQ_SWITCH] = 1'b0;
					end
				end
				`DDC_OFS_IRQ_STAT: s_next.irq_stat = s_reg.irq_stat & ~reg_wdata_in[`DDC_IRQ_W-1:0];
				`DDC_OFS_IRQ_MASK: s_next.irq_mask = reg_wdata_in[`DDC_IRQ_W-1:0];
				`DDC_OFS_SHIFT: begin
					s_next.shdat   = reg_wdata_in;
					s_next.stretch = 1'b0;     // Software has answered, release the clock
				end
				default: ;
			endcase
		end

		// Register reads; window data comes from the buffer one cycle later
		if (reg_rd_in) begin
			s_next.rd_buf = win_acc;
			unique case (reg_addr_in)
				`DDC_OFS_LDATA: s_next.rdata = s_reg.ldata;
				`DDC_OFS_POINTER: s_next.rdata = s_reg.ptr;
				`DDC_OFS_CONTROL: s_next.rdata = {1'b0, s_reg.size_sel, s_reg.sw_acc, s_reg.wild,
					s_reg.irq_stat[`DDC_IRQ_LBYTE], s_reg.legacy_en,
					s_reg.irq_stat[`DDC_IRQ_SWITCH], s_reg.mode};
				`DDC_OFS_IRQ_STAT: s_next.rdata = {5'h00, s_reg.irq_stat};
				`DDC_OFS_IRQ_MASK: s_next.rdata = {5'h00, s_reg.irq_mask};
				`DDC_OFS_SHIFT: begin
					s_next.rdata   = s_reg.shdat;
					s_next.stretch = 1'b0;
				end
				default: s_next.rdata = 8'h00;   // Unmapped and blocked window read zero
			endcase
		end

		// Every permitted window access steps the pointer
		if (win_acc) begin
			s_next.ptr = ptr_step(s_reg.ptr, s_reg.size_sel);
		end

		// Disabled: back to legacy mode, both links quiet
		if (!enabled) begin
			s_next.mode    = 1'b0;
			s_next.st      = ST_IDLE;
			s_next.i_drive = 1'b0;
			s_next.stretch = 1'b0;
			s_next.l_cnt   = `DDC_BITS_BYTE;
		end

		// ------------------------------------------------------------
		// Legacy transmitter, clocked by vsync
		// ------------------------------------------------------------
		if (s_reg.legacy_en && !s_reg.mode && vs_rise) begin
			if (s_reg.l_cnt == `DDC_BITS_BYTE) begin
				// Ninth clock: fetch the next byte
				s_next.l_cnt = 4'h0;
				if (s_reg.sw_acc) begin
					s_next.l_sh = s_reg.ldata;
					s_next.irq_stat[`DDC_IRQ_LBYTE] = 1'b1;
				end else begin
					s_next.l_sh = buf_if.rdata;
					s_next.ptr  = ptr_step(s_reg.ptr, s_reg.size_sel);
				end
			end else begin
				s_next.l_sh  = {s_reg.l_sh[6:0], 1'b1};
				s_next.l_cnt = 4'(s_reg.l_cnt + 4'h1);
			end
		end

		// ------------------------------------------------------------
		// Serial bus slave
		// ------------------------------------------------------------
		if (!i2c_enable_in || i_stop) begin
			s_next.st      = ST_IDLE;
			s_next.i_drive = 1'b0;
		end else if (i_start) begin
			s_next.st      = ST_ADDR;
			s_next.i_cnt   = 4'h0;
			s_next.i_drive = 1'b0;
			// First bus activity moves the unit into serial mode until the unit is disabled
			if (!s_reg.mode) begin
				s_next.mode = 1'b1;
				s_next.irq_stat[`DDC_IRQ_SWITCH] = 1'b1;
			end
		end else begin
			unique case (s_reg.st)
				ST_IDLE: ;
				ST_ADDR, ST_RX: begin
					if (scl_rise) begin
						s_next.i_sh  = {s_reg.i_sh[6:0], s_reg.sda_s[2]};
						s_next.i_cnt = 4'(s_reg.i_cnt + 4'h1);
					end else if (scl_fall && s_reg.i_cnt == `DDC_BITS_BYTE) begin
						if (s_reg.st == ST_ADDR) begin
							// Foreign address: drop off the bus until the next start
							s_next.st      = addr_match ? ST_AACK : ST_IDLE;
							s_next.i_drive = addr_match;
							s_next.i_rw    = s_reg.i_sh[0];
							s_next.i_first = 1'b1;
						end else begin
							s_next.st      = ST_RACK;
							s_next.i_drive = 1'b1;
							s_next.i_first = 1'b0;
							if (s_reg.sw_acc) begin
								// Byte left for software, clock held until it answers
								s_next.shdat   = s_reg.i_sh;
								s_next.stretch = 1'b1;
								s_next.irq_stat[`DDC_IRQ_IBYTE] = 1'b1;
							end else if (s_reg.i_first) begin
								s_next.ptr = s_reg.i_sh;   // First written byte is the offset
							end
						end
					end
				end
				ST_AACK: begin
					if (scl_fall) begin
						s_next.i_cnt   = 4'h0;
						s_next.i_drive = 1'b0;
						s_next.st      = ST_RX;
						tx_load        = s_reg.i_rw;
					end
				end
				ST_RACK: begin
					if (scl_fall) begin
						s_next.i_cnt   = 4'h0;
						s_next.i_drive = 1'b0;
						s_next.st      = ST_RX;
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (s_reg.i_cnt == `DDC_LAST_BIT) begin
							s_next.i_drive = 1'b0;
							s_next.st      = ST_TACK;
						end else begin
							s_next.i_sh    = {s_reg.i_sh[6:0], 1'b1};
							s_next.i_drive = !s_reg.i_sh[6];
							s_next.i_cnt   = 4'(s_reg.i_cnt + 4'h1);
						end
					end
				end
				ST_TACK: begin
					if (scl_rise) begin
						s_next.i_nak = s_reg.sda_s[2];
					end else if (scl_fall) begin
						s_next.st = ST_IDLE;
						tx_load   = !s_reg.i_nak;   // Refused byte ends the read
					end
				end
				default: begin
					s_next.st      = ST_IDLE;
					s_next.i_drive = 1'b0;
				end
			endcase
		end

		// Load of the next byte to send on the bus
		if (tx_load) begin
			if (s_reg.sw_acc) begin
				s_next.irq_stat[`DDC_IRQ_IBYTE] = 1'b1;
			end else begin
				tx_byte    = buf_if.rdata;
				s_next.ptr = ptr_step(s_reg.ptr, s_reg.size_sel);
			end
			s_next.i_sh    = tx_byte;
			s_next.i_cnt   = 4'h0;
			s_next.i_drive = !tx_byte[7];
			s_next.st      = ST_TX;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_reg   <= DDC_STATE_RST;
			xrd_reg <= 1'b0;
		end else begin
			s_reg   <= s_next;
			xrd_reg <= x_acc && xdata_rd_in;
		end
	end

	// ----------------------------------------------------------------
	// Buffer port: processor in software mode, hardware otherwise
	// ----------------------------------------------------------------
	always_comb begin
		buf_if.we    = 1'b0;
		buf_if.wdata = reg_wdata_in;
		buf_if.addr  = hw_idx;   // Hardware prefetches at the pointer
		if (win_acc) begin
			buf_if.addr = s_reg.ptr;
			buf_if.we   = reg_wr_in;
		end else if (x_acc) begin
			buf_if.addr  = xdata_addr_in[7:0];
			buf_if.wdata = xdata_wdata_in;
			buf_if.we    = xdata_wr_in;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rdata_out   = s_reg.rd_buf ? buf_if.rdata : s_reg.rdata;
	assign xdata_rdata_out = xrd_reg ? buf_if.rdata : 8'h00;
	// The window stays with the unit whenever it is enabled, even when blocked
	assign xdata_claim_out = enabled || s_reg.sw_acc;
	assign scl_out         = 1'b0;
	assign scl_oe_n_out    = !s_reg.stretch;
	assign sda_out         = 1'b0;
	// Legacy bits are released on the ninth clock and in serial mode
	assign sda_oe_n_out    = !(s_reg.i_drive || (s_reg.legacy_en && !s_reg.mode &&
		s_reg.l_cnt != `DDC_BITS_BYTE && !s_reg.l_sh[7]));
	assign irq_out         = |(s_reg.irq_stat & s_reg.irq_mask);
endmodule : ddc_ctrl
`default_nettype wire

// ===== sim/ddc_ctrl_checker.sv
// Port-level assertions of the display data channel controller
`timescale 1ns/10ps
`default_nettype none
module ddc_ctrl_checker (
	input wire logic        clk_in,
	input wire logic        rst_n_in,
	input wire logic [7:0]  reg_addr_in,
	input wire logic [7:0]  reg_wdata_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [7:0]  reg_rdata_out,
	input wire logic        i2c_enable_in,
	input wire logic [15:0] xdata_addr_in,
	input wire logic        xdata_rd_in,
	input wire logic [7:0]  xdata_rdata_out,
	input wire logic        xdata_claim_out,
	input wire logic        sda_out,
	input wire logic        scl_out,
	input wire logic        sda_oe_n_out,
	input wire logic        scl_oe_n_out,
	input wire logic        irq_out
);
	logic mask_zero_reg; // Mask last written as all zero
	// Track the mask so a masked event can be told apart
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mask_zero_reg <= 1'b1;
		end else if (reg_wr_in && reg_addr_in == 8'hD9) begin
			mask_zero_reg <= (reg_wdata_in[2:0] == 3'h0);
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// Pointer write, idle cycle, pointer read
	sequence ptr_wr_rd;
		reg_wr_in && reg_addr_in == 8'hD6 ##2 reg_rd_in && reg_addr_in == 8'hD6;
	endsequence
	a_ptr_readback: assert property (ptr_wr_rd |=> reg_rdata_out == $past(reg_wdata_in, 3))
		else $error("pointer readback differs");
	a_mask_quiet: assert property (mask_zero_reg |-> !irq_out)
		else $error("interrupt with all events masked");
	a_enable_claims: assert property (i2c_enable_in |-> xdata_claim_out)
		else $error("enabled unit gave up its data space");
	a_blocked_read: assert property (xdata_rd_in && !xdata_claim_out |=> xdata_rdata_out == 8'h00)
		else $error("blocked data space read returned data");
	a_outside_read: assert property (xdata_rd_in && xdata_addr_in[15:8] != 8'hFF |=> xdata_rdata_out == 8'h00)
		else $error("read outside buffer space returned data");
	a_unmapped_read: assert property (reg_rd_in && (reg_addr_in < 8'hD4 || reg_addr_in > 8'hDA)
		|=> reg_rdata_out == 8'h00)
		else $error("unmapped register read not zero");
	a_idle_quiet: assert property (!xdata_claim_out [*3] |-> sda_oe_n_out && scl_oe_n_out)
		else $error("disabled unit drives a bus line");
	a_ctrl_top_bit: assert property (reg_rd_in && reg_addr_in == 8'hD7 |=> !reg_rdata_out[7])
		else $error("reserved control bit reads one");
	a_data_low: assert property (sda_out == 1'b0)
		else $error("data line driven high");
	a_clk_low: assert property (scl_out == 1'b0)
		else $error("clock line driven high");
endmodule : ddc_ctrl_checker
bind ddc_ctrl ddc_ctrl_checker chk (.clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
	.reg_rd_in, .reg_rdata_out, .i2c_enable_in, .xdata_addr_in, .xdata_rd_in, .xdata_rdata_out,
	.xdata_claim_out, .sda_out, .scl_out, .sda_oe_n_out, .scl_oe_n_out, .irq_out);
`default_nettype wire

// ===== sim/ddc_host_model.sv
// Display host model: vsync clock source and serial bus master
`timescale 1ns/10ps
`default_nettype none
module ddc_host_model (
	input  wire logic sda_oe_n_in,
	input  wire logic scl_oe_n_in,
	output logic      vsync_out,
	output logic      scl_out,
	output logic      sda_out
);
	logic scl_drv; // Master clock drive, high is released
	logic sda_drv; // Master data drive, high is released
	// Pulled-up lines: low if either party pulls
	assign scl_out = scl_drv & scl_oe_n_in;
	assign sda_out = sda_drv & sda_oe_n_in;
	initial begin
		vsync_out = 1'b0;
		scl_drv = 1'b1;
		sda_drv = 1'b1;
	end
	// Vsync runs only inside a frame, 320 ns period
	task automatic vs_pulse(input int n);
		repeat (n) begin
			vsync_out = 1'b1;
			#160 vsync_out = 1'b0;
			#160;
		end
	endtask : vs_pulse
	// Start or repeated start: data falls while clock high
	task automatic start();
		#80 sda_drv = 1'b1;
		#80 scl_drv = 1'b1;
		#80 sda_drv = 1'b0;
		#80 scl_drv = 1'b0;
	endtask : start
	task automatic stop();
		#80 sda_drv = 1'b0;
		#80 scl_drv = 1'b1;
		#80 sda_drv = 1'b1;
	endtask : stop
	// Nine clocks; a one in tx releases the line so the slave may drive
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			#80 sda_drv = tx[i];
			#80 scl_drv = 1'b1;
			// A stretching slave holds the clock; resume just off the edge that frees it
			if (!scl_oe_n_in) wait (scl_oe_n_in) #1;
			#80 rx[i] = sda_out;
			#80 scl_drv = 1'b0;
		end
	endtask : xfer
endmodule : ddc_host_model
`default_nettype wire

// ===== sim/tb_ddc_ctrl.sv
// Self-checking bench of the display data channel controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin miscompares++; \
	$display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_ddc_ctrl;
	logic        clk_in, rst_n_in, reg_wr_in, reg_rd_in, i2c_enable_in, xdata_wr_in, xdata_rd_in;
	logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out, xdata_wdata_in, xdata_rdata_out;
	logic [15:0] xdata_addr_in;
	logic        xdata_claim_out, scl_out, scl_oe_n_out, sda_out, sda_oe_n_out, irq_out;
	logic        vsync_in, scl_in, sda_in;
	logic [8:0]  r;                       // Last bus transfer seen by master
	int          miscompares, num_checks;
	localparam logic [7:0] LD = 8'h5A;    // Legacy byte, mixed bits
	// Register reset rows: address, expected value
	logic [15:0] rows [8] = '{16'hD400, 16'hD500, 16'hD600, 16'hD700,
		16'hD800, 16'hD900, 16'hDA00, 16'hDB00};
	ddc_ctrl dut (.clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
		.i2c_enable_in, .xdata_addr_in, .xdata_wdata_in, .xdata_wr_in, .xdata_rd_in, .xdata_rdata_out,
		.xdata_claim_out, .vsync_in, .scl_in, .scl_out, .scl_oe_n_out, .sda_in, .sda_out, .sda_oe_n_out, .irq_out);
	ddc_host_model host (.sda_oe_n_in(sda_oe_n_out), .scl_oe_n_in(scl_oe_n_out),
		.vsync_out(vsync_in), .scl_out(scl_in), .sda_out(sda_in));
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	// Register access; for a read d is the expected value
	task automatic rg(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= w;
		reg_rd_in <= !w;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
		reg_rd_in <= 1'b0;
		#1 if (!w) `CHK("reg", d, reg_rdata_out)
	endtask : rg
	task automatic xa(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_in);
		xdata_addr_in <= a;
		xdata_wdata_in <= d;
		xdata_wr_in <= w;
		xdata_rd_in <= !w;
		@(posedge clk_in);
		xdata_wr_in <= 1'b0;
		xdata_rd_in <= 1'b0;
		#1 if (!w) `CHK("xdata", d, xdata_rdata_out)
	endtask : xa
	task automatic send(input logic [7:0] b, input logic nak);
		host.xfer({b, 1'b1}, r);
		`CHK("ack", nak, r[0])
	endtask : send
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test
	// Whole run is near 36 us; a hang is cut at 1 ms
	initial begin
		#1000000;
		miscompares++;
		finish_test();
	end
	initial begin
		{rst_n_in, reg_wr_in, reg_rd_in, xdata_wr_in, xdata_rd_in, i2c_enable_in} = '0;
		{reg_addr_in, reg_wdata_in, xdata_addr_in, xdata_wdata_in} = '0;
		repeat (16) @(posedge clk_in);
		rst_n_in <= 1'b1;
		foreach (rows[i]) rg(1'b0, rows[i][15:8], rows[i][7:0]);
		$display("reset test done");
		// Load buffer while disabled with software access
		rg(1'b1, 8'hD7, 8'h20);
		rg(1'b1, 8'hD6, 8'h00);
		for (int i = 0; i < 4; i++) rg(1'b1, 8'hD4, 8'hA0 + 8'(i));
		rg(1'b0, 8'hD6, 8'h04);
		rg(1'b1, 8'hD6, 8'h02);
		rg(1'b0, 8'hD6, 8'h02);
		rg(1'b0, 8'hD4, 8'hA2);
		rg(1'b0, 8'hD6, 8'h03);
		xa(1'b1, 16'hFF05, 8'h3C);
		xa(1'b0, 16'hFF01, 8'hA1);
		xa(1'b0, 16'hFF05, 8'h3C);
		for (int s = 0; s < 2; s++) begin
			rg(1'b1, 8'hD7, s ? 8'h60 : 8'h20);
			rg(1'b1, 8'hD6, 8'h7F);
			rg(1'b1, 8'hD4, 8'h11);
			rg(1'b0, 8'hD6, s ? 8'h80 : 8'h00);
		end
		$display("load test done");
		// Automatic mode hides the buffer
		rg(1'b1, 8'hD7, 8'h00);
		`CHK("claim", 1'b0, xdata_claim_out)
		xa(1'b0, 16'hFF01, 8'h00);
		@(posedge clk_in) i2c_enable_in <= 1'b1;
		xa(1'b0, 16'hFF01, 8'h00);
		rg(1'b0, 8'hD4, 8'h00);
		// Bus write of offset 2, then read back from the buffer
		host.start();
		send(8'hA0, 1'b0);
		send(8'h02, 1'b0);
		host.start();
		send(8'hA1, 1'b0);
		host.xfer(9'h1FF, r);
		`CHK("rdata", 8'hA2, r[8:1])
		host.stop();
		rg(1'b0, 8'hD7, 8'h03);
		rg(1'b1, 8'hD9, 8'h01);
		`CHK("irq", 1'b1, irq_out)
		rg(1'b1, 8'hD8, 8'h01);
		`CHK("irq", 1'b0, irq_out)
		rg(1'b0, 8'hD7, 8'h01);
		host.start();
		send(8'hA2, 1'b1);
		host.stop();
		// Software mode write: byte left in shift data, clock held until software reads it
		rg(1'b1, 8'hD7, 8'h20);
		host.start();
		send(8'hA0, 1'b0);
		fork
			send(8'h3C, 1'b0);
			begin
				wait (!scl_oe_n_out);
				rg(1'b0, 8'hD8, 8'h04);
				rg(1'b0, 8'hDA, 8'h3C);
			end
		join
		host.stop();
		rg(1'b1, 8'hD7, 8'h10);
		host.start();
		send(8'hA6, 1'b0);
		host.stop();
		@(posedge clk_in) i2c_enable_in <= 1'b0;
		rg(1'b0, 8'hD7, 8'h10);
		$display("bus test done");
		// Legacy link: ignored while off, then software-fed byte
		rg(1'b1, 8'hD8, 8'h07);
		rg(1'b1, 8'hD7, 8'h20);
		host.vs_pulse(9);
		rg(1'b0, 8'hD8, 8'h00);
		rg(1'b1, 8'hD5, LD);
		rg(1'b1, 8'hD7, 8'h24);
		`CHK("claim", 1'b1, xdata_claim_out)
		for (int i = 7; i >= 0; i--) begin
			host.vs_pulse(1);
			`CHK("bit", LD[i], sda_oe_n_out)
		end
		rg(1'b0, 8'hD8, 8'h02);
		$display("legacy test done");
		finish_test();
	end
endmodule : tb_ddc_ctrl
`default_nettype wire
